// [logic/acm_edge_meter.sv]
/*
  Samples the bit clock and frame sync pins, and measures each frame in
  bit-clock edges and core cycles.
  Assumes both pins are asynchronous to core_clk and much slower.
*/
`default_nettype none
module acm_edge_meter #(
  parameter int unsigned LOST_CYC = 16000
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        bitClkPin,
  input  wire logic        frameSyncPin,
  output logic             frameDone,
  output logic [9:0]       bitsPerFrame,
  output logic [15:0]      cyclesPerFrame,
  output logic             clockLost
);
  logic [2:0]  bitSh_ff;
  logic [2:0]  fsSh_ff;
  logic [9:0]  bitCnt_ff;
  logic [15:0] cycCnt_ff;
  logic        seen_ff;
  logic        bitRise;
  logic        fsRise;

  // Two flops ahead of the edge detector; only stages two and three feed logic.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bitSh_ff <= 3'h0;
      fsSh_ff  <= 3'h0;
    end else begin
      bitSh_ff <= {bitSh_ff[1:0], bitClkPin};
      fsSh_ff  <= {fsSh_ff[1:0], frameSyncPin};
    end
  end

  assign bitRise = bitSh_ff[1] & ~bitSh_ff[2];
  assign fsRise  = fsSh_ff[1] & ~fsSh_ff[2];

  // Counters saturate so a stopped clock cannot wrap into a valid value.
  always_ff @(posedge core_clk) begin
    if (!rst_n || fsRise) begin
      bitCnt_ff <= 10'h000;
      cycCnt_ff <= 16'h0001;
    end else begin
      if (bitRise && bitCnt_ff != 10'h3FF) bitCnt_ff <= bitCnt_ff + 10'h001;
      if (cycCnt_ff != 16'hFFFF) cycCnt_ff <= cycCnt_ff + 16'h0001;
    end
  end

  // A frame is reported only between two frame starts, never after a stall.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      seen_ff        <= 1'b0;
      frameDone      <= 1'b0;
      clockLost      <= 1'b0;
      bitsPerFrame   <= 10'h000;
      cyclesPerFrame <= 16'h0000;
    end else begin
      frameDone <= fsRise & seen_ff;
      clockLost <= ~fsRise & (cycCnt_ff >= LOST_CYC[15:0]);
      if (fsRise) begin
        seen_ff        <= 1'b1;
        bitsPerFrame   <= bitCnt_ff;
        cyclesPerFrame <= cycCnt_ff;
      end else if (cycCnt_ff >= LOST_CYC[15:0]) begin
        seen_ff <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [logic/acm_params.svh]
/*
  Constants for the audio clock monitor: register offsets, field
  positions, reset values, rate bands and timing figures.
  Assumes a 200 MHz core clock and an 8-bit register port.
*/
// Notes on behaviour
// - Mode 11 toggles active/shutdown on clock validity.
// - Wake mode: shutdown until clocks valid, then active.
// - Protect enable (reset 1) gates fault checking.
// - Clock fault with protection triggers orderly shutdown.
// - Wait timer code: 000 infinite, 001-111 preset times.
// - Wait expiry without clocks sets group four bit 2.
// - Running faults set group two bit 3.
// - Generic flag accompanies specific flags, not pre-power.
// - Bits 2,1,0: ratio change, rate change, rate invalid.
// - Bit 5 frame sync lost, bit 4 internal clock.
// - Per-flag mask bits; several flags at once.
// - After clock fault shutdown, retry in mode 11.
// - Measure rate and ratio, report read-only.
// - Bad clock or ratio ramps volume down.
// - Ratio set and rate-specific ratio limits.
// - 192 kHz input flagged for decimation to 96 kHz.
// - Watchdog on control state machine shuts down.
// - Rate field 3 bits, ratio field 4 bits.
// - Rate codes 001..110, 111 error, 000 reserved.
`ifndef ACM_PARAMS_SVH
`define ACM_PARAMS_SVH

`define ACM_CLK_MHZ        200
// Register offsets.
`define ACM_REG_CTRL       4'h0
`define ACM_REG_STAT2      4'h1
`define ACM_REG_MASK2      4'h2
`define ACM_REG_STAT4      4'h3
`define ACM_REG_MASK4      4'h4
`define ACM_REG_DETECT     4'h5
`define ACM_REG_STATE      4'h6
// Control fields and reset values.
`define ACM_MODE_ON        2'h0
`define ACM_MODE_WAKE      2'h3
`define ACM_MODE_RST       2'h2
`define ACM_PROT_RST       1'h1
`define ACM_HALT_RST       3'h1
`define ACM_MASK_RST       8'h00
// Group bit positions.
`define ACM_B2_FSINV       0
`define ACM_B2_FSCHG       1
`define ACM_B2_RATIOCHG    2
`define ACM_B2_GENERIC     3
`define ACM_B2_INTCLK      4
`define ACM_B2_SYNC        5
`define ACM_B4_WDOG        1
`define ACM_B4_PREPWR      2
// Detected rate codes.
`define ACM_RATE_16K       3'h1
`define ACM_RATE_24K       3'h2
`define ACM_RATE_32K       3'h3
`define ACM_RATE_48K       3'h4
`define ACM_RATE_96K       3'h5
`define ACM_RATE_192K      3'h6
`define ACM_RATE_ERR       3'h7
`define ACM_RATIO_RST      4'h4
`define ACM_RATIO_ERR      4'hF
// Core cycles per frame, band edges per rate family.
`define ACM_BAND_16K       16'h2AF8, 16'h38A4
`define ACM_BAND_24K       16'h1D4C, 16'h2580
`define ACM_BAND_32K       16'h15E0, 16'h1C84
`define ACM_BAND_48K       16'h0E74, 16'h1324
`define ACM_BAND_96K       16'h073A, 16'h0992
`define ACM_BAND_192K      16'h0398, 16'h04CE
// Times in microseconds.
`define ACM_HALT1_US       800
`define ACM_HALT2_US       3200
`define ACM_HALT3_US       34100
`define ACM_HALT4_US       68300
`define ACM_HALT5_US       256000
`define ACM_HALT6_US       768000
`define ACM_HALT7_US       1300000
`define ACM_LOST_US        80
`define ACM_RAMP_US        5

`endif

// [logic/acm_pkg.sv]
/*
  Types of the audio clock monitor.
  Assumes nothing beyond a SystemVerilog elaborator.
*/
`default_nettype none
package acm_pkg;
  // Power control states; unused codes are caught by the watchdog.
  typedef enum logic [2:0] {
    ACM_SHUT   = 3'b000,
    ACM_WAIT   = 3'b001,
    ACM_RAMP   = 3'b010,
    ACM_ACTIVE = 3'b011
  } acm_state_t;
endpackage
`default_nettype wire

// [logic/acm_wait_timer.sv]
/*
  Pre-power-up wait timer: counts the selected time and pulses once.
  Assumes start is a one-cycle pulse and run holds while waiting.
*/
`default_nettype none
module acm_wait_timer #(
  parameter int unsigned CYC1 = 160000,
  parameter int unsigned CYC2 = 640000,
  parameter int unsigned CYC3 = 6820000,
  parameter int unsigned CYC4 = 13660000,
  parameter int unsigned CYC5 = 51200000,
  parameter int unsigned CYC6 = 153600000,
  parameter int unsigned CYC7 = 260000000
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic        run,
  input  wire logic [2:0]  code,
  output logic             expired
);
  logic [31:0] cnt_ff;
  logic [31:0] limit;

  // Code zero never expires, which keeps the block out of shutdown.
  always_comb begin
    unique case (code)
      3'h0: limit = 32'hFFFFFFFF;
      3'h1: limit = CYC1;
      3'h2: limit = CYC2;
      3'h3: limit = CYC3;
      3'h4: limit = CYC4;
      3'h5: limit = CYC5;
      3'h6: limit = CYC6;
      3'h7: limit = CYC7;
    endcase
  end

  // The count stops at the limit so the expiry pulse comes only once.
  always_ff @(posedge core_clk) begin
    if (!rst_n || start) begin
      cnt_ff  <= 32'h00000000;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (run && code != 3'h0 && cnt_ff < limit) begin
        cnt_ff  <= cnt_ff + 32'h00000001;
        expired <= (cnt_ff + 32'h00000001 == limit);
      end
    end
  end
endmodule
`default_nettype wire

// [logic/audio_clock_monitor.sv]
/*
  Audio clock monitor: detects sample rate and bit-clock ratio, powers the
  amplifier up and down with the clocks, latches clock faults and drives
  the open-drain interrupt line.
  Assumes a 200 MHz core_clk, synchronous active-low reset, and a
  register master that never issues read and write together.
*/
`include "acm_params.svh"
`default_nettype none
module audio_clock_monitor #(
  parameter int unsigned HALT_CYC1 = `ACM_HALT1_US * `ACM_CLK_MHZ,
  parameter int unsigned HALT_CYC2 = `ACM_HALT2_US * `ACM_CLK_MHZ,
  parameter int unsigned HALT_CYC3 = `ACM_HALT3_US * `ACM_CLK_MHZ,
  parameter int unsigned HALT_CYC4 = `ACM_HALT4_US * `ACM_CLK_MHZ,
  parameter int unsigned HALT_CYC5 = `ACM_HALT5_US * `ACM_CLK_MHZ,
  parameter int unsigned HALT_CYC6 = `ACM_HALT6_US * `ACM_CLK_MHZ,
  parameter int unsigned HALT_CYC7 = `ACM_HALT7_US * `ACM_CLK_MHZ,
  parameter int unsigned LOST_CYC  = `ACM_LOST_US * `ACM_CLK_MHZ
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdData,
  input  wire logic        serialBitClock,
  input  wire logic        frameSync,
  input  wire logic        internalClockFault,
  output logic             ampActive,
  output logic             volumeRampDown,
  output logic             decimateEnable,
  output logic      [2:0]  detectedSampleRate,
  output logic      [3:0]  detectedClockRatio,
  output logic             interruptRequestN,
  output logic             interruptRequestOeN
);
  localparam int unsigned RAMP_CYC = `ACM_RAMP_US * `ACM_CLK_MHZ;

  acm_pkg::acm_state_t state_ff;
  acm_pkg::acm_state_t nxt_state;

  logic [1:0]  mode_ff;
  logic        protectEn_ff;
  logic [2:0]  haltCode_ff;
  logic [7:0]  stat2_ff;
  logic [7:0]  mask2_ff;
  logic [7:0]  stat4_ff;
  logic [7:0]  mask4_ff;
  logic [1:0]  goodCnt_ff;
  logic        badClk_ff;
  logic [15:0] rampCnt_ff;
  logic        frameDone;
  logic [9:0]  bitsPerFrame;
  logic [15:0] cyclesPerFrame;
  logic        clockLost;
  logic        timerExpired;
  logic [2:0]  newRate;
  logic [3:0]  newRatio;
  logic        comboBad;
  logic        frameGood;
  logic        clocksValid;
  logic        modeOn;
  logic        modeWake;
  logic        modeOff;
  logic        checking;
  logic [7:0]  set2;
  logic [7:0]  set4;
  logic        anyFault;
  logic        waitStart;
  logic        wdogTrip;

  acm_edge_meter #(
    .LOST_CYC (LOST_CYC)
  ) u_meter (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .bitClkPin      (serialBitClock),
    .frameSyncPin   (frameSync),
    .frameDone      (frameDone),
    .bitsPerFrame   (bitsPerFrame),
    .cyclesPerFrame (cyclesPerFrame),
    .clockLost      (clockLost)
  );

  acm_wait_timer #(
    .CYC1 (HALT_CYC1),
    .CYC2 (HALT_CYC2),
    .CYC3 (HALT_CYC3),
    .CYC4 (HALT_CYC4),
    .CYC5 (HALT_CYC5),
    .CYC6 (HALT_CYC6),
    .CYC7 (HALT_CYC7)
  ) u_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .start    (waitStart),
    .run      (state_ff == acm_pkg::ACM_WAIT),
    .code     (haltCode_ff),
    .expired  (timerExpired)
  );

  // Map the measured bit count onto the ratio code; counts not listed are errors.
  function automatic logic [3:0] ratioCode(input logic [9:0] b);
    case (b)
      10'h010: ratioCode = 4'h0;
      10'h018: ratioCode = 4'h1;
      10'h020: ratioCode = 4'h2;
      10'h030: ratioCode = 4'h3;
      10'h040: ratioCode = 4'h4;
      10'h060: ratioCode = 4'h5;
      10'h080: ratioCode = 4'h6;
      10'h0C0: ratioCode = 4'h7;
      10'h100: ratioCode = 4'h8;
      10'h180: ratioCode = 4'h9;
      10'h200: ratioCode = 4'hA;
      10'h07D: ratioCode = 4'hB;
      10'h0FA: ratioCode = 4'hC;
      10'h1F4: ratioCode = 4'hD;
      default: ratioCode = `ACM_RATIO_ERR;
    endcase
  endfunction

  // Each band covers both the 48 kHz and 44.1 kHz families.
  always_comb begin
    if (cyclesPerFrame >= 16'h2AF8 && cyclesPerFrame <= 16'h38A4)
      newRate = `ACM_RATE_16K;
    else if (cyclesPerFrame >= 16'h1D4C && cyclesPerFrame <= 16'h2580)
      newRate = `ACM_RATE_24K;
    else if (cyclesPerFrame >= 16'h15E0 && cyclesPerFrame <= 16'h1C84)
      newRate = `ACM_RATE_32K;
    else if (cyclesPerFrame >= 16'h0E74 && cyclesPerFrame <= 16'h1324)
      newRate = `ACM_RATE_48K;
    else if (cyclesPerFrame >= 16'h073A && cyclesPerFrame <= 16'h0992)
      newRate = `ACM_RATE_96K;
    else if (cyclesPerFrame >= 16'h0398 && cyclesPerFrame <= 16'h04CE)
      newRate = `ACM_RATE_192K;
    else
      newRate = `ACM_RATE_ERR;
  end

  // Rate-specific ratio limits on top of the plain ratio set.
  assign newRatio  = ratioCode(bitsPerFrame);
  assign comboBad  = (newRate == `ACM_RATE_96K && bitsPerFrame > 10'h100) ||
                     (newRate == `ACM_RATE_192K && bitsPerFrame > 10'h080) ||
                     (newRate == `ACM_RATE_16K && bitsPerFrame == 10'h010);
  assign frameGood = newRate != `ACM_RATE_ERR && newRatio != `ACM_RATIO_ERR &&
                     !comboBad;
  assign clocksValid = goodCnt_ff == 2'h2;

  assign modeOn   = mode_ff == `ACM_MODE_ON;
  assign modeWake = mode_ff == `ACM_MODE_WAKE;
  assign modeOff  = !modeOn && !modeWake;
  assign checking = protectEn_ff && state_ff == acm_pkg::ACM_ACTIVE;

  // Two good frames in a row make the clocks valid; one bad frame undoes it.
  always_ff @(posedge core_clk) begin
    if (!rst_n || clockLost) begin
      goodCnt_ff <= 2'h0;
    end else if (frameDone) begin
      if (!frameGood) goodCnt_ff <= 2'h0;
      else if (!clocksValid) goodCnt_ff <= goodCnt_ff + 2'h1;
    end
  end

  // Detected fields follow every measured frame.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      detectedSampleRate <= `ACM_RATE_48K;
      detectedClockRatio <= `ACM_RATIO_RST;
    end else if (frameDone) begin
      detectedSampleRate <= newRate;
      detectedClockRatio <= newRatio;
    end
  end

  // Running faults; the generic bit rides with each specific one.
  always_comb begin
    set2 = 8'h00;
    if (checking) begin
      if (clockLost || (frameDone && newRate == `ACM_RATE_ERR))
        set2[`ACM_B2_FSINV] = 1'b1;
      if (frameDone && newRate != `ACM_RATE_ERR && newRate != detectedSampleRate)
        set2[`ACM_B2_FSCHG] = 1'b1;
      if (frameDone && newRatio != `ACM_RATIO_ERR && newRatio != detectedClockRatio)
        set2[`ACM_B2_RATIOCHG] = 1'b1;
      if (frameDone && (newRatio == `ACM_RATIO_ERR || comboBad))
        set2[`ACM_B2_SYNC] = 1'b1;
      if (internalClockFault)
        set2[`ACM_B2_INTCLK] = 1'b1;
      if (set2 != 8'h00)
        set2[`ACM_B2_GENERIC] = 1'b1;
    end
  end
  assign anyFault = set2 != 8'h00;

  // Pre-power fault stands alone, without the generic bit.
  always_comb begin
    set4 = 8'h00;
    if (state_ff == acm_pkg::ACM_WAIT && timerExpired && !clocksValid && protectEn_ff)
      set4[`ACM_B4_PREPWR] = 1'b1;
    if (wdogTrip)
      set4[`ACM_B4_WDOG] = 1'b1;
  end

  // Power control sequence.
  always_comb begin
    nxt_state = state_ff;
    waitStart = 1'b0;
    wdogTrip  = 1'b0;
    unique case (state_ff)
      acm_pkg::ACM_SHUT: begin
        // Wake mode leaves shutdown only once frames appear, which also
        // serves as the retry after a fault shutdown.
        if (modeOn || (modeWake && frameDone)) begin
          nxt_state = acm_pkg::ACM_WAIT;
          waitStart = 1'b1;
        end
      end
      acm_pkg::ACM_WAIT: begin
        if (modeOff) nxt_state = acm_pkg::ACM_SHUT;
        else if (clocksValid) nxt_state = acm_pkg::ACM_ACTIVE;
        else if (timerExpired) nxt_state = acm_pkg::ACM_SHUT;
      end
      acm_pkg::ACM_ACTIVE: begin
        // A fault goes through the ramp so the output does not click.
        if (modeOff || anyFault || (modeWake && !clocksValid))
          nxt_state = acm_pkg::ACM_RAMP;
      end
      acm_pkg::ACM_RAMP: begin
        if (rampCnt_ff == RAMP_CYC[15:0]) nxt_state = acm_pkg::ACM_SHUT;
      end
      default: begin
        nxt_state = acm_pkg::ACM_SHUT;
        wdogTrip  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) state_ff <= acm_pkg::ACM_SHUT;
    else state_ff <= nxt_state;
  end

  // Ramp length counter; it restarts on every entry to the ramp.
  always_ff @(posedge core_clk) begin
    if (!rst_n || state_ff != acm_pkg::ACM_RAMP) rampCnt_ff <= 16'h0000;
    else rampCnt_ff <= rampCnt_ff + 16'h0001;
  end

  // Bad clocks seen while playing pull the volume down even unprotected.
  always_ff @(posedge core_clk) begin
    if (!rst_n || state_ff != acm_pkg::ACM_ACTIVE) badClk_ff <= 1'b0;
    else if (clockLost || (frameDone && !frameGood)) badClk_ff <= 1'b1;
    else if (frameDone) badClk_ff <= 1'b0;
  end

  // Control register; protection enable resets to one.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_ff      <= `ACM_MODE_RST;
      protectEn_ff <= `ACM_PROT_RST;
      haltCode_ff  <= `ACM_HALT_RST;
    end else if (regWr && regAddr == `ACM_REG_CTRL) begin
      mode_ff      <= regWrData[1:0];
      protectEn_ff <= regWrData[2];
      haltCode_ff  <= regWrData[5:3];
    end
  end

  // Mask registers, one bit per flag position.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mask2_ff <= `ACM_MASK_RST;
      mask4_ff <= `ACM_MASK_RST;
    end else if (regWr) begin
      if (regAddr == `ACM_REG_MASK2) mask2_ff <= regWrData;
      if (regAddr == `ACM_REG_MASK4) mask4_ff <= regWrData;
    end
  end

  // Sticky flags, cleared by writing ones; a new event beats the clear.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stat2_ff <= 8'h00;
      stat4_ff <= 8'h00;
    end else begin
      stat2_ff <= (stat2_ff & ~((regWr && regAddr == `ACM_REG_STAT2) ? regWrData : 8'h00))
                  | set2;
      stat4_ff <= (stat4_ff & ~((regWr && regAddr == `ACM_REG_STAT4) ? regWrData : 8'h00))
                  | set4;
    end
  end

  // Read data stand in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        `ACM_REG_CTRL:   regRdData <= {2'h0, haltCode_ff, protectEn_ff, mode_ff};
        `ACM_REG_STAT2:  regRdData <= stat2_ff;
        `ACM_REG_MASK2:  regRdData <= mask2_ff;
        `ACM_REG_STAT4:  regRdData <= stat4_ff;
        `ACM_REG_MASK4:  regRdData <= mask4_ff;
        `ACM_REG_DETECT: regRdData <= {1'h0, detectedSampleRate, detectedClockRatio};
        `ACM_REG_STATE:  regRdData <= {4'h0, clocksValid, state_ff};
        default:         regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

  // Open-drain line: driven low only while an unmasked flag stands.
  always_ff @(posedge core_clk) begin
    if (!rst_n) interruptRequestN <= 1'b1;
    else interruptRequestN <= ((stat2_ff & ~mask2_ff) == 8'h00) &&
                              ((stat4_ff & ~mask4_ff) == 8'h00);
  end
  assign interruptRequestOeN = interruptRequestN;

  // Status outputs; 192 kHz input is marked for decimation to 96 kHz.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ampActive      <= 1'b0;
      volumeRampDown <= 1'b0;
      decimateEnable <= 1'b0;
    end else begin
      ampActive      <= nxt_state == acm_pkg::ACM_ACTIVE;
      volumeRampDown <= nxt_state == acm_pkg::ACM_RAMP || badClk_ff;
      decimateEnable <= detectedSampleRate == `ACM_RATE_192K;
    end
  end
endmodule
`default_nettype wire

// [verif/acm_host_clocks.sv]
/*
  Host side model: makes the bit clock and frame sync.
  Assumes the bench sets bits per frame and starts or stops frames.
*/
`default_nettype none
module acm_host_clocks (
  input  wire logic       run,
  input  wire logic [9:0] bitsPerFrame,
  output var  logic       bitClk,
  output var  logic       frameSync
);
  timeunit 1ns;
  timeprecision 1ps;
  int count;

  // Frames go out whole at a 64 ns bit period; the clock stands low between bursts.
  initial begin
    bitClk = 1'b0;
    frameSync = 1'b0;
    forever begin
      wait (run === 1'b1);
      count = bitsPerFrame; // Ratio only changes at a frame start.
      for (int i = 0; i < count; i++) begin
        frameSync = (i < count / 2);
        #32 bitClk = 1'b1;
        #32 bitClk = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/acm_monitor_properties.sv]
/*
  Port checker for the audio clock monitor.
  Assumes one core_clk domain and is bound to every monitor instance.
*/
`default_nettype none
module acm_monitor_props (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdData,
  input wire logic       ampActive,
  input wire logic       volumeRampDown,
  input wire logic       decimateEnable,
  input wire logic [2:0] detectedSampleRate,
  input wire logic [3:0] detectedClockRatio,
  input wire logic       interruptRequestN,
  input wire logic       interruptRequestOeN
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Leaving active must start a ramp that lasts, or the speaker pops.
  sequence s_ramp;
    volumeRampDown [*8];
  endsequence
  property p_ramp_off;
    $fell(ampActive) |-> s_ramp;
  endproperty
  a_ramp_off: assert property (p_ramp_off) else $error("shutdown without ramp");

  property p_oe_follows;
    interruptRequestOeN == interruptRequestN;
  endproperty
  a_oe_follows: assert property (p_oe_follows) else $error("irq enable differs");

  property p_reset_out;
    $rose(rst_n) |-> interruptRequestN && !ampActive && detectedSampleRate == 3'h4;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("bad outputs after reset");

  // The line only rises through a clear or mask write, one or two cycles late.
  property p_irq_hold;
    !interruptRequestN && !regWr && !$past(regWr) |=> !interruptRequestN;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq released alone");

  property p_rd_quiet;
    !regRd |=> regRdData == 8'h00;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data without read");

  property p_rate_legal;
    detectedSampleRate != 3'h0;
  endproperty
  a_rate_legal: assert property (p_rate_legal) else $error("reserved rate code");

  property p_ratio_legal;
    detectedClockRatio != 4'hE;
  endproperty
  a_ratio_legal: assert property (p_ratio_legal) else $error("unused ratio code");

  property p_decim;
    (detectedSampleRate == 3'h6) [*3] |-> decimateEnable;
  endproperty
  a_decim: assert property (p_decim) else $error("no decimation at top rate");
endmodule

bind audio_clock_monitor acm_monitor_props u_props (
  .core_clk, .rst_n, .regWr, .regRd, .regRdData, .ampActive, .volumeRampDown,
  .decimateEnable, .detectedSampleRate, .detectedClockRatio, .interruptRequestN,
  .interruptRequestOeN
);
`default_nettype wire

// [verif/tb.sv]
/*
  Self-checking bench of the audio clock monitor.
  Assumes a 200 MHz core clock and the host clock model beside it.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk, rst_n, regWr, regRd, internalClockFault, run;
  logic       bitClk, frameSync, ampActive, decimateEnable, interruptRequestN;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData, rd;
  logic [9:0] ratio;
  int         errCount, checks, cycles;
  // Reset table: index beside expected value, unmapped index last.
  localparam logic [11:0] ROWS [8] = '{12'h00E, 12'h100, 12'h200, 12'h300,
                                       12'h400, 12'h544, 12'h600, 12'hF00};

  // Short wait codes stand in for the long times; frames run about 1230 to 6550 cycles.
  audio_clock_monitor #(.HALT_CYC1(40000), .HALT_CYC2(300), .LOST_CYC(8000)) DUT (
    .core_clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .serialBitClock(bitClk), .frameSync, .internalClockFault, .ampActive,
    .volumeRampDown(), .decimateEnable, .detectedSampleRate(),
    .detectedClockRatio(), .interruptRequestN, .interruptRequestOeN());
  acm_host_clocks host (.run, .bitsPerFrame(ratio), .bitClk, .frameSync);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      errCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic writeReg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic readReg(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask
  // Bounded wait on ampActive (0), the irq line (1) or decimation (2).
  task automatic waitSig(input int sel, input logic want, input int lim);
    logic [2:0] s;
    for (int n = 0; n < lim; n++) begin
      s = {decimateEnable, interruptRequestN, ampActive};
      if (s[sel] === want) break;
      @(posedge core_clk);
    end
    s = {decimateEnable, interruptRequestN, ampActive};
    check({7'h00, s[sel]}, {7'h00, want});
  endtask
  task automatic testDone();
    $display("checks %0d mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // A hang is cut off well after the longest expected run.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 95000) begin
      errCount++;
      testDone();
    end
  end

  initial begin
    {rst_n, regWr, regRd, internalClockFault, run} = 5'h00;
    {regAddr, regWrData} = 12'h000;
    ratio = 10'h180;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (ROWS[i]) begin
      readReg(ROWS[i][11:8], rd);
      check(rd, ROWS[i][7:0]);
    end
    check({6'h00, ampActive, interruptRequestN}, 8'h01);
    $display("test reset done");
    // Out-of-band frames never validate, so the short wait runs out.
    writeReg(4'h0, 8'h17); // Wake mode with a finite wait code.
    run <= 1'b1;
    waitSig(1, 1'b0, 20000);
    readReg(4'h3, rd);
    check(rd, 8'h04);
    readReg(4'h1, rd);
    check(rd, 8'h00);
    check({7'h00, ampActive}, 8'h00);
    writeReg(4'h4, 8'h04);
    waitSig(1, 1'b1, 4);
    $display("test prepower done");
    // Protection stays on here, or the internal fault below is never latched.
    writeReg(4'h0, 8'h0F);
    ratio <= 10'h200;
    writeReg(4'h3, 8'h04);
    waitSig(0, 1'b1, 40000);
    readReg(4'h5, rd);
    check(rd, 8'h3A);
    check({7'h00, decimateEnable}, 8'h00);
    $display("test wake done");
    internalClockFault <= 1'b1;
    @(posedge core_clk);
    internalClockFault <= 1'b0;
    waitSig(0, 1'b0, 1500);
    readReg(4'h1, rd);
    check(rd, 8'h18);
    check({7'h00, interruptRequestN}, 8'h00);
    writeReg(4'h2, 8'h18);
    waitSig(1, 1'b1, 4);
    waitSig(0, 1'b1, 40000);
    readReg(4'h1, rd);
    check(rd, 8'h18);
    $display("test internal fault done");
    ratio <= 10'h1F4;
    waitSig(1, 1'b0, 20000);
    readReg(4'h1, rd);
    check(rd, 8'h1C);
    waitSig(0, 1'b0, 1500);
    writeReg(4'h1, 8'hFF);
    readReg(4'h1, rd);
    check(rd, 8'h00);
    $display("test ratio change done");
    ratio <= 10'h060;
    waitSig(2, 1'b1, 12000);
    readReg(4'h5, rd);
    check(rd, 8'h65);
    $display("test top rate done");
    testDone();
  end
endmodule
`default_nettype wire
